/* File: frse_map.vh */
`ifndef FRSE_MAP_VH
`define FRSE_MAP_VH
// ****************************************
// termination codes of the first byte
// ****************************************
`define FRSE_TERM_NORMAL 2'h0
`define FRSE_TERM_ABNORMAL 2'h1
`define FRSE_TERM_INVALID 2'h2
`define FRSE_TERM_POLLING 2'h3
// ****************************************
// first byte field positions
// ****************************************
`define FRSE_S0_TERM_HI 7
`define FRSE_S0_TERM_LO 6
`define FRSE_S0_POS_DONE 5
`define FRSE_S0_HW_FAULT 4
`define FRSE_S0_HEAD 2
// ****************************************
// second byte field positions
// ****************************************
`define FRSE_S1_END_TRACK 7
`define FRSE_S1_CRC_ANY 5
`define FRSE_S1_OVERRUN 4
`define FRSE_S1_SECT_MISS 2
`define FRSE_S1_WP_VIOL 1
`define FRSE_S1_ID_SYNC 0
// ****************************************
// third byte field positions
// ****************************************
`define FRSE_S2_CTRL_MARK 6
`define FRSE_S2_CRC_PAY 5
`define FRSE_S2_TRK_MISM 4
`define FRSE_S2_BAD_TRK 1
`define FRSE_S2_PAY_SYNC 0
// ****************************************
// fourth byte field positions and fixed ones
// ****************************************
`define FRSE_S3_WP 6
`define FRSE_S3_TRACK_ZERO_PIN 4
`define FRSE_S3_SIDE 2
`define FRSE_S3_FIXED 8'h28
// ****************************************
// result sets, limits, reset values
// ****************************************
`define FRSE_SET_ERR3 2'h0
`define FRSE_SET_ST0 2'h1
`define FRSE_SET_ST3 2'h2
`define FRSE_RECAL_STEPS 80
`define FRSE_ID_INDEX_LIMIT 2
`define FRSE_BAD_TRACK 8'hFF
`define FRSE_DATA_RESET 8'h00
`endif

/* File: frse_result_status_encoder.v */
// Function
// - status bytes read out one by one
// - first byte bits 7:6 termination code
// - first byte bit 5 on positioning done
// - fault if no track zero after 80 steps
// - fault when relative seek passes track zero
// - first byte head bit, drive bits 1:0
// - second byte bit 7 end of track
// - second byte bit 5 any CRC fault
// - second byte bit 4 overrun or underrun
// - second byte bit 2 sector missing cases
// - second byte bit 1 write protect violation
// - second byte bit 0 address mark absent
// - unused bits fixed at zero or one
// - third byte bit 6 wrong mark type
// - third byte bit 5 payload CRC fault
// - third byte bit 4 track mismatch
// - third byte bit 0 payload mark absent
// - fourth byte mirrors drive pins
`timescale 1ns/1ps
`default_nettype none
`include "frse_map.vh"
module frse_result_status_encoder #(
  parameter RECAL_STEPS = `FRSE_RECAL_STEPS, // step pulses before recalibrate gives up
  parameter STEP_W = 7 // width of the step counter
) (
  input wire clk_sys,
  input wire reset_n,
  input wire cmd_start, // pulse: execution begins, sticky errors clear
  input wire cmd_end, // pulse: command finished, result phase starts
  input wire [1:0] result_set, // which bytes the command returns
  input wire cmd_invalid, // level at cmd_end: command was not executable
  input wire cmd_polling, // level at cmd_end: ended by drive polling
  input wire cmd_xfer, // level: read or write data command running
  input wire cmd_read_deleted, // level: read deleted data command running
  input wire cmd_read_normal, // level: read data command running
  input wire cmd_write, // level: write, write deleted or format running
  input wire recal_active, // level: recalibrate stepping
  input wire step_pulse, // pulse: one head step issued
  input wire rel_seek_underflow, // pulse: relative seek stepped past track zero
  input wire seek_complete, // pulse: seek, relative seek or recal done
  input wire sector_past_end, // pulse: access beyond last sector
  input wire transfer_end_strobe, // pulse: terminal count from the host side
  input wire crc_fault_id, // pulse: CRC mismatch in an ID field
  input wire crc_fault_data, // pulse: CRC mismatch in a data field
  input wire fifo_overrun, // pulse: FIFO not serviced in time
  input wire sector_not_found, // pulse: read, read ID or read track failure
  input wire id_search, // level: hunting for an ID address mark
  input wire payload_mark_missing, // pulse: no data or deleted mark found
  input wire mark_deleted_seen, // pulse: deleted data mark met
  input wire mark_normal_seen, // pulse: normal data mark met
  input wire id_valid, // pulse: ID field track number on id_track
  input wire [7:0] id_track, // track number read from the ID field
  input wire [7:0] current_track, // internally kept track number
  input wire head_select_state, // head currently addressed
  input wire [1:0] unit_select_bits, // drive currently selected
  input wire side_select_pin, // side select output as driven
  input wire write_protect_pin, // asynchronous drive pin
  input wire track_zero_pin, // asynchronous drive pin
  input wire index_pulse_n_pin, // asynchronous drive pin, active low
  input wire host_data_read, // pulse: host reads the data register
  output reg [7:0] result_data_q, // byte on the data register
  output reg host_service_request_q, // host may transfer
  output reg transfer_direction_q, // 1 means host reads
  output reg result_busy_q // result phase in progress
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] wp_sync_q; // [0] feeds only [1]
  reg [1:0] track_zero_pin_sync_q;
  reg [1:0] index_sync_q;
  reg index_prev_q; // for edge detect on the settled level

  // two stages before any logic sees a drive pin
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wp_sync_q <= 2'b00;
      track_zero_pin_sync_q <= 2'b00;
      index_sync_q <= 2'b11;
      index_prev_q <= 1'b1;
    end else begin
      wp_sync_q <= {wp_sync_q[0], write_protect_pin};
      track_zero_pin_sync_q <= {track_zero_pin_sync_q[0], track_zero_pin};
      index_sync_q <= {index_sync_q[0], index_pulse_n_pin};
      index_prev_q <= index_sync_q[1];
    end
  end

  wire wp_level = wp_sync_q[1];
  wire track_zero_pin_level = track_zero_pin_sync_q[1];
  wire index_fall = index_prev_q & ~index_sync_q[1]; // leading edge of index

  // ****************************************
  // sticky error flags
  // ****************************************
  reg hardware_fault_q;
  reg positioning_done_q; // outlives the command, consumed by a result
  reg end_track_q;
  reg crc_fault_any_field_q;
  reg overrun_q;
  reg sector_missing_flag_q;
  reg write_protect_violation_q;
  reg id_sync_absent_q;
  reg control_mark_q;
  reg crc_fault_payload_q;
  reg track_mismatch_q;
  reg bad_track_hit_q;
  reg payload_sync_absent_q;
  reg tc_seen_q; // terminal count met during this command
  reg [STEP_W-1:0] step_cnt_q; // steps during recalibrate
  reg [1:0] index_cnt_q; // index edges while hunting an ID mark

  wire recal_limit = recal_active & step_pulse & ~track_zero_pin_level &
                     (step_cnt_q == RECAL_STEPS - 1);
  wire id_limit = id_search & index_fall &
                  (index_cnt_q == `FRSE_ID_INDEX_LIMIT - 1);
  wire trk_differs = id_valid & (id_track != current_track);
  wire snap = cmd_end & ~result_busy_q; // moment the result is latched

  // flag helper: a set in the same cycle as a clear wins
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  // collect events during execution; cleared at command start, positioning done at the result latch
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      hardware_fault_q <= 1'b0;
      positioning_done_q <= 1'b0;
      end_track_q <= 1'b0;
      crc_fault_any_field_q <= 1'b0;
      overrun_q <= 1'b0;
      sector_missing_flag_q <= 1'b0;
      write_protect_violation_q <= 1'b0;
      id_sync_absent_q <= 1'b0;
      control_mark_q <= 1'b0;
      crc_fault_payload_q <= 1'b0;
      track_mismatch_q <= 1'b0;
      bad_track_hit_q <= 1'b0;
      payload_sync_absent_q <= 1'b0;
      tc_seen_q <= 1'b0;
    end else begin
      hardware_fault_q <= flag_next(hardware_fault_q,
                                    recal_limit | rel_seek_underflow, cmd_start);
      positioning_done_q <= flag_next(positioning_done_q, seek_complete, snap);
      end_track_q <= flag_next(end_track_q, sector_past_end, cmd_start);
      crc_fault_any_field_q <= flag_next(crc_fault_any_field_q,
                                         crc_fault_id | crc_fault_data, cmd_start);
      overrun_q <= flag_next(overrun_q, fifo_overrun, cmd_start);
      sector_missing_flag_q <= flag_next(sector_missing_flag_q, sector_not_found, cmd_start);
      write_protect_violation_q <= flag_next(write_protect_violation_q,
                                             cmd_write & wp_level, cmd_start);
      id_sync_absent_q <= flag_next(id_sync_absent_q,
                                    id_limit | payload_mark_missing, cmd_start);
      control_mark_q <= flag_next(control_mark_q,
                                  (cmd_read_normal & mark_deleted_seen) |
                                  (cmd_read_deleted & mark_normal_seen), cmd_start);
      crc_fault_payload_q <= flag_next(crc_fault_payload_q, crc_fault_data, cmd_start);
      track_mismatch_q <= flag_next(track_mismatch_q, trk_differs, cmd_start);
      bad_track_hit_q <= flag_next(bad_track_hit_q,
                                   trk_differs & (id_track == `FRSE_BAD_TRACK), cmd_start);
      payload_sync_absent_q <= flag_next(payload_sync_absent_q, payload_mark_missing, cmd_start);
      tc_seen_q <= flag_next(tc_seen_q, transfer_end_strobe, cmd_start);
    end
  end

  // ****************************************
  // step and index counters
  // ****************************************
  // counts restart whenever their activity stops
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      step_cnt_q <= {STEP_W{1'b0}};
      index_cnt_q <= 2'b00;
    end else begin
      if (!recal_active || track_zero_pin_level) begin
        step_cnt_q <= {STEP_W{1'b0}};
      end else if (step_pulse && step_cnt_q != RECAL_STEPS - 1) begin
        step_cnt_q <= step_cnt_q + 1'b1;
      end
      if (!id_search) begin
        index_cnt_q <= 2'b00;
      end else if (index_fall && index_cnt_q != `FRSE_ID_INDEX_LIMIT - 1) begin
        index_cnt_q <= index_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // result snapshot
  // ****************************************
  reg [7:0] snap0_q; // first byte as latched
  reg [7:0] snap1_q;
  reg [7:0] snap2_q;
  reg [1:0] set_q; // which bytes this result holds
  reg [1:0] idx_q; // next byte to hand out
  reg [1:0] term_d;
  reg any_error;

  // termination code from the ending condition
  always @* begin
    any_error = hardware_fault_q | end_track_q | crc_fault_any_field_q | overrun_q |
                sector_missing_flag_q | write_protect_violation_q | id_sync_absent_q |
                control_mark_q | track_mismatch_q | (cmd_xfer & ~tc_seen_q);
    if (cmd_invalid) begin
      term_d = `FRSE_TERM_INVALID;
    end else if (cmd_polling) begin
      term_d = `FRSE_TERM_POLLING;
    end else if (any_error) begin
      term_d = `FRSE_TERM_ABNORMAL;
    end else begin
      term_d = `FRSE_TERM_NORMAL;
    end
  end

  // latch once at the end; held until the last byte is read
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      snap0_q <= `FRSE_DATA_RESET;
      snap1_q <= `FRSE_DATA_RESET;
      snap2_q <= `FRSE_DATA_RESET;
      set_q <= `FRSE_SET_ERR3;
    end else if (snap) begin
      snap0_q <= 8'h00; // unused bit 3 stays zero
      snap0_q[`FRSE_S0_TERM_HI:`FRSE_S0_TERM_LO] <= term_d;
      snap0_q[`FRSE_S0_POS_DONE] <= positioning_done_q | seek_complete;
      snap0_q[`FRSE_S0_HW_FAULT] <= hardware_fault_q;
      snap0_q[`FRSE_S0_HEAD] <= head_select_state;
      snap0_q[1:0] <= unit_select_bits;
      snap1_q <= 8'h00; // bits 6 and 3 stay zero
      snap1_q[`FRSE_S1_END_TRACK] <= end_track_q | (cmd_xfer & ~tc_seen_q);
      snap1_q[`FRSE_S1_CRC_ANY] <= crc_fault_any_field_q;
      snap1_q[`FRSE_S1_OVERRUN] <= overrun_q;
      snap1_q[`FRSE_S1_SECT_MISS] <= sector_missing_flag_q;
      snap1_q[`FRSE_S1_WP_VIOL] <= write_protect_violation_q;
      snap1_q[`FRSE_S1_ID_SYNC] <= id_sync_absent_q;
      snap2_q <= 8'h00; // bits 7, 3 and 2 stay zero
      snap2_q[`FRSE_S2_CTRL_MARK] <= control_mark_q;
      snap2_q[`FRSE_S2_CRC_PAY] <= crc_fault_payload_q;
      snap2_q[`FRSE_S2_TRK_MISM] <= track_mismatch_q;
      snap2_q[`FRSE_S2_BAD_TRK] <= bad_track_hit_q;
      snap2_q[`FRSE_S2_PAY_SYNC] <= payload_sync_absent_q;
      set_q <= result_set;
    end
  end

  // ****************************************
  // fourth byte, live from the pins
  // ****************************************
  // built every cycle so a read sees the pins as they are now
  wire [7:0] pin_byte = `FRSE_S3_FIXED | // bits 5 and 3 high, bit 7 low
                        ({7'h00, wp_level} << `FRSE_S3_WP) |
                        ({7'h00, track_zero_pin_level} << `FRSE_S3_TRACK_ZERO_PIN) |
                        ({7'h00, side_select_pin} << `FRSE_S3_SIDE) |
                        {6'h00, unit_select_bits};

  // ****************************************
  // byte sequencer
  // ****************************************
  localparam ST_IDLE = 1'b0; // no result pending
  localparam ST_SEND = 1'b1; // bytes waiting for the host
  reg state_q;
  reg [1:0] last_idx; // index of the final byte of this set
  reg [7:0] byte_sel; // byte at idx_q

  // how many bytes this set has, and which one is up
  always @* begin
    case (set_q)
      `FRSE_SET_ST0: last_idx = 2'd0;
      `FRSE_SET_ST3: last_idx = 2'd0;
      default: last_idx = 2'd2;
    endcase
    if (set_q == `FRSE_SET_ST3) begin
      byte_sel = pin_byte;
    end else begin
      case (idx_q)
        2'd0: byte_sel = snap0_q;
        2'd1: byte_sel = snap1_q;
        2'd2: byte_sel = snap2_q;
        default: byte_sel = 8'h00;
      endcase
    end
  end

  // a read is honoured only while request and direction both show read
  wire read_ok = host_data_read & host_service_request_q & transfer_direction_q;

  // hand bytes out in order; a stray read outside the phase is ignored
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      idx_q <= 2'd0;
      result_busy_q <= 1'b0;
      host_service_request_q <= 1'b0;
      transfer_direction_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (snap) begin
            state_q <= ST_SEND;
            idx_q <= 2'd0;
            result_busy_q <= 1'b1;
            host_service_request_q <= 1'b1;
            transfer_direction_q <= 1'b1;
          end
        end
        ST_SEND: begin
          if (read_ok) begin
            if (idx_q == last_idx) begin
              state_q <= ST_IDLE; // snapshot may now be replaced
              result_busy_q <= 1'b0;
              transfer_direction_q <= 1'b0;
              idx_q <= 2'd0;
            end else begin
              idx_q <= idx_q + 2'd1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          result_busy_q <= 1'b0;
        end
      endcase
      if (state_q == ST_IDLE && !snap) begin
        host_service_request_q <= 1'b1; // ready for the next command byte
      end
    end
  end

  // ****************************************
  // data register output
  // ****************************************
  // registered, one cycle behind the index change
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      result_data_q <= `FRSE_DATA_RESET;
    end else if (state_q == ST_SEND) begin
      result_data_q <= byte_sel;
    end else begin
      result_data_q <= `FRSE_DATA_RESET;
    end
  end

endmodule // frse_result_status_encoder
`default_nettype wire

/* File: frse_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// result phase checker
// ****
module frse_props #(
  parameter RECAL_STEPS = 80, // recal limit, not used here
  parameter STEP_W = 7 // step counter width
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cmd_end,
  input wire logic [1:0] result_set,
  input wire logic head_select_state,
  input wire logic [1:0] unit_select_bits,
  input wire logic host_data_read,
  input wire logic [7:0] result_data_q,
  input wire logic host_service_request_q,
  input wire logic transfer_direction_q,
  input wire logic result_busy_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [1:0] set_q; // result set of this phase
  logic [1:0] rd_q; // reads taken this phase
  logic [2:0] hu_q; // head and unit at command end
  logic busy_old_q; // busy one cycle back
  logic take_old_q; // read taken one cycle back
  wire take = host_data_read && host_service_request_q && transfer_direction_q && result_busy_q;
  // byte on the port only settles one edge after a read
  wire valid = result_busy_q && busy_old_q && !take_old_q;
  wire pin_set = (set_q == 2'h2);
  wire [1:0] last_v = (set_q == 2'h1 || pin_set) ? 2'h0 : 2'h2;
  // ****
  // phase tracking from the ports
  // ****
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      set_q <= 2'h0;
      rd_q <= 2'h0;
      hu_q <= 3'h0;
      busy_old_q <= 1'b0;
      take_old_q <= 1'b0;
    end else begin
      busy_old_q <= result_busy_q;
      take_old_q <= take;
      if (cmd_end && !result_busy_q) begin // accepted end
        set_q <= result_set;
        rd_q <= 2'h0;
        hu_q <= {head_select_state, unit_select_bits};
      end else if (take) begin
        rd_q <= rd_q + 2'h1;
      end
    end
  end
  a_phase_opens: assert property (cmd_end && !result_busy_q |=> result_busy_q && host_service_request_q)
    else $error("result phase did not open");
  a_dir_with_busy: assert property (transfer_direction_q == result_busy_q)
    else $error("direction differs from busy");
  a_idle_data_zero: assert property (!result_busy_q && !busy_old_q |-> result_data_q == 8'h00)
    else $error("data not zero when idle");
  a_first_spare: assert property (valid && !pin_set && rd_q == 2'h0 |-> !result_data_q[3] && result_data_q[2:0] == hu_q)
    else $error("first byte head unit or spare wrong");
  a_second_spare: assert property (valid && !pin_set && rd_q == 2'h1 |-> !result_data_q[6] && !result_data_q[3])
    else $error("second byte spare bits set");
  a_third_spare: assert property (valid && !pin_set && rd_q == 2'h2 |-> (result_data_q & 8'h8C) == 8'h00)
    else $error("third byte spare bits set");
  a_pin_fixed: assert property (valid && pin_set |-> (result_data_q & 8'hA8) == 8'h28)
    else $error("pin byte fixed bits wrong");
  a_bytes_hold: assert property (valid && !pin_set && !take |=> $stable(result_data_q))
    else $error("latched byte changed");
  a_phase_closes: assert property (take && rd_q == last_v |=> !result_busy_q)
    else $error("phase did not close");
  a_phase_goes_on: assert property (take && rd_q != last_v |=> result_busy_q)
    else $error("phase closed early");
  c_three_bytes: cover property (take && rd_q == 2'h2);
  c_pin_byte: cover property (cmd_end && !result_busy_q && result_set == 2'h2);
  c_end_ignored: cover property (cmd_end && result_busy_q);
endmodule // frse_props
bind frse_result_status_encoder frse_props #(.RECAL_STEPS(RECAL_STEPS), .STEP_W(STEP_W)) frse_props_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .cmd_end(cmd_end), .result_set(result_set),
  .head_select_state(head_select_state), .unit_select_bits(unit_select_bits),
  .host_data_read(host_data_read), .result_data_q(result_data_q),
  .host_service_request_q(host_service_request_q), .transfer_direction_q(transfer_direction_q),
  .result_busy_q(result_busy_q));
`default_nettype wire

/* File: frse_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// host reading result bytes
// ****
module frse_host (
  input wire logic clk_sys,
  input wire logic host_service_request_q,
  input wire logic transfer_direction_q,
  input wire logic result_busy_q,
  input wire logic [7:0] result_data_q,
  output logic host_data_read
);
  int slow = 0; // extra idle cycles before a read
  int n = 0; // bytes taken this command
  int wait_c = 0; // cycles since phase start or read
  logic [7:0] got [0:3]; // bytes taken
  initial host_data_read = 1'b0;
  // read held until its edge, then byte taken at that edge
  always @(posedge clk_sys) begin
    if (host_data_read) begin
      if (n < 4) got[n] = result_data_q;
      n = n + 1;
      wait_c = 0;
      #1 host_data_read = 1'b0;
    end else if (host_service_request_q && transfer_direction_q && result_busy_q) begin
      if (wait_c >= 1 + slow) #1 host_data_read = 1'b1;
      else wait_c = wait_c + 1;
    end else begin
      wait_c = 0;
    end
  end
endmodule // frse_host
`default_nettype wire

/* File: frse_result_status_encoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
// ****
// bench top
// ****
module frse_result_status_encoder_tb;
  localparam int STEPS = 4; // short recal limit
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [14:0] pv = 15'h0000; // one bit per pulse input
  logic inv = 1'b0, pol = 1'b0, xfer = 1'b0, rdel = 1'b0, rnorm = 1'b0, wr = 1'b0, recal = 1'b0;
  logic srch = 1'b0, head = 1'b0, side = 1'b0, wp = 1'b0, t0 = 1'b0, idx_n = 1'b1;
  logic [1:0] unit = 2'h1, rs = 2'h0;
  logic [7:0] id_trk = 8'h00, cur_trk = 8'h00;
  wire logic [7:0] data;
  wire logic host_service_request, dir, busy, rd;
  int err_total = 0;
  int comparisons = 0;
  frse_result_status_encoder #(.RECAL_STEPS(STEPS), .STEP_W(7)) frse_result_status_encoder_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .cmd_start(pv[0]), .cmd_end(pv[1]), .result_set(rs),
    .cmd_invalid(inv), .cmd_polling(pol), .cmd_xfer(xfer), .cmd_read_deleted(rdel), .cmd_read_normal(rnorm),
    .cmd_write(wr), .recal_active(recal), .step_pulse(pv[2]), .rel_seek_underflow(pv[3]),
    .seek_complete(pv[4]), .sector_past_end(pv[5]), .transfer_end_strobe(pv[6]), .crc_fault_id(pv[7]),
    .crc_fault_data(pv[8]), .fifo_overrun(pv[9]), .sector_not_found(pv[10]), .id_search(srch),
    .payload_mark_missing(pv[11]), .mark_deleted_seen(pv[12]), .mark_normal_seen(pv[13]), .id_valid(pv[14]),
    .id_track(id_trk), .current_track(cur_trk), .head_select_state(head), .unit_select_bits(unit),
    .side_select_pin(side), .write_protect_pin(wp), .track_zero_pin(t0), .index_pulse_n_pin(idx_n),
    .host_data_read(rd), .result_data_q(data), .host_service_request_q(host_service_request), .transfer_direction_q(dir),
    .result_busy_q(busy));
  frse_host frse_host_i (.clk_sys(clk_sys), .host_service_request_q(host_service_request), .transfer_direction_q(dir),
    .result_busy_q(busy), .result_data_q(data), .host_data_read(rd));
  always #12.5 clk_sys = ~clk_sys;
  // one-cycle pulses on the masked inputs
  task automatic pulse(input logic [14:0] m);
    @(posedge clk_sys) #1 pv = m;
    @(posedge clk_sys) #1 pv = 15'h0000;
  endtask
  // end the command, let the host read, bounded wait
  task automatic finish_cmd(input logic [1:0] s, input int nb);
    int k;
    k = 0;
    frse_host_i.n = 0;
    rs = s;
    pulse(15'h0002);
    while (frse_host_i.n < nb && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("bytes read", nb, frse_host_i.n)
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic chk3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    `CHK("first", a, frse_host_i.got[0])
    `CHK("second", b, frse_host_i.got[1])
    `CHK("third", c, frse_host_i.got[2])
  endtask
  // slow host, faults and a second end injected mid-phase
  task automatic t_clean();
    head = 1'b1;
    unit = 2'h2;
    frse_host_i.slow = 6;
    pulse(15'h0001);
    fork
      finish_cmd(2'h0, 3);
      begin
        repeat (8) @(posedge clk_sys);
        pulse(15'h0302);
      end
    join
    chk3(8'h06, 8'h00, 8'h00);
    head = 1'b0;
    unit = 2'h1;
    frse_host_i.slow = 0;
    $display("clean done");
  endtask
  // every error of a read in one command, set 3
  task automatic t_errors();
    pulse(15'h0001);
    xfer = 1'b1;
    rnorm = 1'b1;
    cur_trk = 8'h03;
    id_trk = 8'hFF;
    pulse(15'h5F20);
    finish_cmd(2'h3, 3);
    chk3(8'h41, 8'hB5, 8'h73);
    xfer = 1'b0;
    rnorm = 1'b0;
    $display("errors done");
  endtask
  // id crc only, protected write, wrong mark, plain mismatch
  task automatic t_crc_id();
    pulse(15'h0001);
    xfer = 1'b1;
    rdel = 1'b1;
    wr = 1'b1;
    wp = 1'b1;
    cur_trk = 8'h05;
    id_trk = 8'h07;
    pulse(15'h60C0);
    finish_cmd(2'h0, 3);
    chk3(8'h41, 8'h22, 8'h50);
    xfer = 1'b0;
    rdel = 1'b0;
    wr = 1'b0;
    wp = 1'b0;
    $display("crc id done");
  endtask
  // normal, invalid, polling, then invalid and polling both set; seek end in the first
  task automatic t_codes();
    logic [7:0] exp_v [0:3];
    exp_v = '{8'h21, 8'h81, 8'hC1, 8'h81};
    for (int i = 0; i < 4; i++) begin
      pulse(15'h0001);
      inv = i[0];
      pol = i[1];
      if (i == 0) pulse(15'h0010);
      finish_cmd(2'h1, 1);
      `CHK("code", exp_v[i], frse_host_i.got[0])
    end
    inv = 1'b0;
    pol = 1'b0;
    $display("codes done");
  endtask
  // recal one short of the limit, at the limit, then underflow
  task automatic t_fault();
    recal = 1'b1;
    pulse(15'h0001);
    repeat (STEPS - 1) pulse(15'h0004);
    finish_cmd(2'h1, 1);
    `CHK("short recal", 8'h00, frse_host_i.got[0] & 8'h10)
    recal = 1'b0; // a new recalibrate counts from zero again
    pulse(15'h0001);
    recal = 1'b1;
    repeat (STEPS) pulse(15'h0004);
    finish_cmd(2'h1, 1);
    `CHK("recal fault", 8'h10, frse_host_i.got[0] & 8'h10)
    recal = 1'b0;
    pulse(15'h0001);
    pulse(15'h0008);
    finish_cmd(2'h1, 1);
    `CHK("underflow", 8'h10, frse_host_i.got[0] & 8'h10)
    $display("fault done");
  endtask
  // two index edges while hunting for an id mark
  task automatic t_index();
    pulse(15'h0001);
    srch = 1'b1;
    repeat (2) begin
      @(posedge clk_sys) #1 idx_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 idx_n = 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    finish_cmd(2'h0, 3);
    chk3(8'h41, 8'h01, 8'h00);
    srch = 1'b0;
    $display("index done");
  endtask
  // pin byte for two pin patterns
  task automatic t_pins();
    logic [4:0] pin_v [0:1];
    logic [7:0] exp_v [0:1];
    pin_v = '{5'h15, 5'h0A};
    exp_v = '{8'h6D, 8'h3A};
    for (int i = 0; i < 2; i++) begin
      pulse(15'h0001);
      {wp, t0, side, unit} = pin_v[i];
      repeat (4) @(posedge clk_sys);
      finish_cmd(2'h2, 1);
      `CHK("pin byte", exp_v[i], frse_host_i.got[0])
    end
    {wp, t0, side, unit} = 5'h01;
    $display("pins done");
  endtask
  // reset in mid-phase drops the result at once
  task automatic t_reset();
    frse_host_i.slow = 20;
    rs = 2'h0;
    pulse(15'h0002);
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b0;
    @(posedge clk_sys) #1 reset_n = 1'b1;
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset data", 8'h00, data)
    `CHK("reset rqm", 1'b0, host_service_request)
    @(posedge clk_sys) #1;
    `CHK("idle rqm", 1'b1, host_service_request)
    `CHK("idle dir", 1'b0, dir)
    frse_host_i.slow = 0;
    $display("reset done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    t_clean();
    t_errors();
    t_crc_id();
    t_codes();
    t_fault();
    t_index();
    t_pins();
    t_reset();
    conclude();
  end
  // hang guard, far beyond the expected run
  initial begin
    #(25 * 6000);
    err_total++;
    conclude();
  end
endmodule // frse_result_status_encoder_tb
`default_nettype wire
